// ### hw/uatx_params.svh
// constants of the asynchronous serial transmitter
`ifndef UATX_PARAMS_SVH
`define UATX_PARAMS_SVH

`define UATX_BAUD_W       8
`define UATX_TICKS_PER_BIT 64
`define UATX_TICK_W       6
`define UATX_TICK_LAST    6'h3F
`define UATX_FRAME_W      11
`define UATX_BITS_W       4
`define UATX_FRAME8_BITS  4'hA
`define UATX_FRAME9_BITS  4'hB
`define UATX_CTRL_NINTH   0
`define UATX_CTRL_EMPTY   1
`define UATX_CTRL_CLKMODE 4
`define UATX_CTRL_TRANSMIT_ENABLE    5
`define UATX_CTRL_NINE    6
`define UATX_FLAG_TXBUF   1
`define UATX_FLAG_RESET   1'b1

`endif

// ### hw/uatx_pkg.sv
// types shared by the asynchronous serial transmitter
package uatx_pkg;

  typedef struct packed {
    logic       nine;
    logic       ninth;
    logic [7:0] data;
  } uatx_word_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SHIFT
  } uatx_state_t;

endpackage

// ### hw/uatx_buf2.sv
// two-entry transmit word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module uatx_buf2
  import uatx_pkg::*;
(
  input  wire logic        clk,      // core clock
  input  wire logic        rst_n,    // async reset, active low
  input  wire uatx_word_t  inWord,   // word offered by software
  input  wire logic        inValid,  // offer strobe
  output logic             inReady,  // room for a word
  output uatx_word_t       outWord,  // head word, from a register
  output logic             outValid, // head word present
  input  wire logic        outReady  // shifter takes the head
);

  // ==========================================================
  // storage
  uatx_word_t slot_r [2];
  logic [1:0] count_r;
  logic       push;
  logic       pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign inReady  = (count_r != 2'h2);
  assign outValid = (count_r != 2'h0);
  assign outWord  = slot_r[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 2'h0;
    end else begin
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // head slot always holds the oldest word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else begin
      if (pop) begin
        slot_r[0] <= (count_r == 2'h2) ? slot_r[1] : inWord;
      end else if (push && count_r == 2'h0) begin
        slot_r[0] <= inWord;
      end
      if (push && ((count_r == 2'h1 && !pop) || (count_r == 2'h2))) begin
        slot_r[1] <= inWord;
      end
    end
  end

  // ==========================================================
  // checks
  noOverflow_a: assert property (@(posedge clk) disable iff (!rst_n)
    count_r != 2'h3) else $error("buffer count out of range");

endmodule // uatx_buf2

`default_nettype wire

// ### hw/uatx_transmitter.sv
// asynchronous NRZ serial transmitter with buffer, baud generator and pin drive
`timescale 1ns/1ps
`default_nettype none
`include "uatx_params.svh"

module uatx_transmitter
  import uatx_pkg::*;
(
  input  wire logic                     clk,                // 250 MHz core clock
  input  wire logic                     rst_n,              // async reset, active low
  input  wire logic                     sleepMode,          // device asleep
  input  wire logic                     serialPortEnable,   // port enable
  input  wire logic                     transmitEnable,     // transmitter enable
  input  wire logic                     clockedModeSelect,  // 1 = clocked mode
  input  wire logic                     nineBitSelect,      // nine data bits
  input  wire logic                     ninthBitValue,      // ninth data bit
  input  wire logic                     txInterruptEnable,  // buffer-empty irq enable
  input  wire logic [`UATX_BAUD_W-1:0]  baudReloadValue,    // baud divider reload
  input  wire logic [7:0]               bufWrData,          // byte written to buffer
  input  wire logic                     bufWrValid,         // buffer write strobe
  output logic                          bufWrReady,         // buffer has room
  output logic                          txBufferEmptyFlag,  // buffer empty flag
  output logic                          txIrqReq,           // interrupt request
  output logic                          shifterEmptyStatus, // shift register empty
  output logic                          txPinOut,           // serial line level
  output logic                          txPinOe             // high while pin driven
);

  // ==========================================================
  // enables and reset of the transmit logic
  logic txOn;
  logic portOn;
  logic run;
  logic runTx;

  // mode select steers the pin only in asynchronous mode
  assign portOn = serialPortEnable && !clockedModeSelect;
  assign txOn   = portOn && transmitEnable;
  assign run    = portOn && !sleepMode;
  assign runTx  = txOn && !sleepMode;

  // ==========================================================
  // baud generator, runs while the port is enabled and awake
  logic [`UATX_BAUD_W-1:0] baudCnt_r;
  logic                    baudTick;

  assign baudTick = run && (baudCnt_r == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_r <= '0;
    end else if (!portOn) begin
      baudCnt_r <= '0;
    end else if (run) begin
      baudCnt_r <= baudTick ? baudReloadValue : baudCnt_r - 1'b1;
    end
  end

  // ==========================================================
  // transmit buffer
  uatx_word_t bufIn;
  uatx_word_t bufHead;
  logic       bufHeadValid;
  logic       bufInReady;
  logic       loadShifter;

  // ninth bit and its select travel with the byte, so they must be set first
  assign bufIn.nine  = nineBitSelect;
  assign bufIn.ninth = ninthBitValue;
  assign bufIn.data  = bufWrData;

  uatx_buf2 u_buf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inWord   (bufIn),
    .inValid  (bufWrValid && bufWrReady),
    .inReady  (bufInReady),
    .outWord  (bufHead),
    .outValid (bufHeadValid),
    .outReady (loadShifter)
  );

  // ==========================================================
  // shift register and frame sequencing
  uatx_state_t              state_r;
  logic [`UATX_FRAME_W-1:0] shift_r;
  logic [`UATX_BITS_W-1:0]  bitsLeft_r;
  logic [`UATX_TICK_W-1:0]  tickCnt_r;
  logic                     bitStrobe;
  logic                     lastBit;

  // an idle shifter takes the buffer head at the end of the baud cycle
  assign loadShifter = runTx && (state_r == TX_IDLE) && bufHeadValid
                       && baudTick;
  assign bitStrobe   = runTx && (state_r == TX_SHIFT) && baudTick
                       && (tickCnt_r == `UATX_TICK_LAST);
  assign lastBit     = (bitsLeft_r == 4'h1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TX_IDLE;
    end else if (!txOn) begin
      state_r <= TX_IDLE;
    end else begin
      unique case (state_r)
        TX_IDLE: begin
          if (loadShifter) begin
            state_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          // no reload before the stop bit has run its full period
          if (bitStrobe && lastBit) begin
            state_r <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // frame laid out start first; stop bits fill the top so shifts feed ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '1;
    end else if (!txOn) begin
      shift_r <= '1;
    end else if (loadShifter) begin
      shift_r <= {1'b1, bufHead.nine ? bufHead.ninth : 1'b1,
                  bufHead.data, 1'b0};
    end else if (bitStrobe) begin
      shift_r <= {1'b1, shift_r[`UATX_FRAME_W-1:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitsLeft_r <= '0;
    end else if (!txOn) begin
      bitsLeft_r <= '0;
    end else if (loadShifter) begin
      bitsLeft_r <= bufHead.nine ? `UATX_FRAME9_BITS : `UATX_FRAME8_BITS;
    end else if (bitStrobe) begin
      bitsLeft_r <= bitsLeft_r - 1'b1;
    end
  end

  // restarted at load so every bit spans the full tick count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= '0;
    end else if (!txOn || loadShifter) begin
      tickCnt_r <= '0;
    end else if (runTx && baudTick && state_r == TX_SHIFT) begin
      tickCnt_r <= tickCnt_r + 1'b1;
    end
  end

  // ==========================================================
  // status, flag and interrupt request
  // the shifter reaches a port only through txPinOut; its state shows here only as these bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shifterEmptyStatus <= 1'b1;
    end else begin
      shifterEmptyStatus <= (state_r == TX_IDLE);
    end
  end

  // flag follows buffer occupancy: only a write can fill it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBufferEmptyFlag <= `UATX_FLAG_RESET;
    end else begin
      txBufferEmptyFlag <= !bufHeadValid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txIrqReq <= 1'b0;
    end else begin
      txIrqReq <= txBufferEmptyFlag && txInterruptEnable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bufWrReady <= 1'b0;
    end else begin
      // registered ready lags one cycle; it drops for a cycle after each accepted write and stays low while two words wait
      bufWrReady <= bufInReady && !(bufWrValid && bufWrReady);
    end
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txPinOut <= 1'b1;
      txPinOe  <= 1'b0;
    end else begin
      txPinOe  <= txOn;
      txPinOut <= (state_r == TX_SHIFT) ? shift_r[0] : 1'b1;
    end
  end

  // ==========================================================
  // checks
  logic wrFire;
  assign wrFire = bufWrValid && bufWrReady;

  baudReload_a: assert property (@(posedge clk) disable iff (!rst_n)
    baudTick ##1 (portOn && !sleepMode && !$past(sleepMode))
    |-> baudCnt_r == $past(baudReloadValue))
    else $error("baud counter did not reload on tick");

  bitLength_a: assert property (@(posedge clk) disable iff (!rst_n)
    bitStrobe |-> baudTick && tickCnt_r == 6'h3F)
    else $error("bit ended before 64 ticks");

  startBit_a: assert property (@(posedge clk) disable iff (!rst_n)
    loadShifter ##1 txOn |=> !txPinOut && txPinOe)
    else $error("start bit not driven low after load");

  frameLen_a: assert property (@(posedge clk) disable iff (!rst_n)
    loadShifter |=> bitsLeft_r == ($past(bufHead.nine) ? 4'hB : 4'hA))
    else $error("wrong frame length loaded");

  idleHigh_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(state_r) == TX_IDLE |-> txPinOut)
    else $error("idle line not high");

  flagClear_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrFire |-> ##2 !txBufferEmptyFlag)
    else $error("buffer write did not clear empty flag");

  irqGate_a: assert property (@(posedge clk) disable iff (!rst_n)
    txIrqReq |-> $past(txBufferEmptyFlag) && $past(txInterruptEnable))
    else $error("interrupt raised without flag and enable");

  shifterEmpty_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == TX_SHIFT |=> !shifterEmptyStatus)
    else $error("shifter-empty status set while shifting");

  abortFrame_a: assert property (@(posedge clk) disable iff (!rst_n)
    !txOn |=> state_r == TX_IDLE && !txPinOe)
    else $error("disable did not abort transmitter");

  sleepHold_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleepMode && txOn |=> $stable(shift_r) && $stable(tickCnt_r)
    && $stable(baudCnt_r))
    else $error("transmitter moved during sleep");

  noEarlyReload_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == TX_SHIFT && !(bitStrobe && lastBit) && txOn
    |=> state_r == TX_SHIFT)
    else $error("shifter left frame before stop bit");

endmodule // uatx_transmitter

`default_nettype wire

// ### verif/uatx_rx_model.sv
// behavioural far-end receiver that decodes frames seen on the transmit line
`timescale 1ns/1ps
`default_nettype none

module uatx_rx_model (
  input  wire logic       clk,       // core clock
  input  wire logic       serLine,   // resolved line level
  input  wire logic       nine,      // expect nine data bits
  input  wire logic [7:0] reload,    // divider reload in use
  output logic      [8:0] rxWord,    // last decoded word
  output logic            rxFrameOk, // start low and stop high seen
  output int              rxCount    // frames decoded so far
);
  // ==========================================================
  // frame decoder
  int bitClks;

  initial begin
    rxCount = 0;
    rxWord = '0;
    rxFrameOk = 1'b0;
  end

  // samples mid-bit, so a wrong bit period shows up as corrupt data
  always begin
    @(negedge serLine);
    bitClks = 64 * (int'(reload) + 1);
    repeat (bitClks / 2) @(posedge clk);
    rxFrameOk = !serLine;
    rxWord = '0;
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || nine) begin
        repeat (bitClks) @(posedge clk);
        rxWord[i] = serLine;
      end
    end
    repeat (bitClks) @(posedge clk);
    rxFrameOk = rxFrameOk & serLine;
    rxCount++;
  end
endmodule // uatx_rx_model

`default_nettype wire

// ### verif/tb_uatx_transmitter.sv
// self-checking testbench of the asynchronous serial transmitter
`timescale 1ns/1ps
`default_nettype none

module tb_uatx_transmitter;
  import uatx_pkg::*;
  // ==========================================================
  // stimulus and design
  logic clk = 1'b0, rst_n = 1'b0, sleepMode = 1'b0, spe = 1'b0, txe = 1'b0;
  logic cms = 1'b0, nine = 1'b0, ninth = 1'b0, tx_interrupt_enable = 1'b0, bufWrValid = 1'b0;
  logic [7:0] reload = 8'h00, bufWrData = 8'h00;
  logic bufWrReady, flag, irq, status, txPinOut, txPinOe, serLine, rxOk;
  logic [8:0] rxWord;
  int rxCount, failures = 0, numChecks = 0;

  always #2 clk = ~clk;
  // no pull level is given, a high rest is assumed while floated
  assign serLine = (txPinOe === 1'b1) ? txPinOut : 1'b1;

  uatx_transmitter uatx_transmitter_i (.clk(clk), .rst_n(rst_n), .sleepMode(sleepMode),
    .serialPortEnable(spe), .transmitEnable(txe), .clockedModeSelect(cms),
    .nineBitSelect(nine), .ninthBitValue(ninth), .txInterruptEnable(tx_interrupt_enable),
    .baudReloadValue(reload), .bufWrData(bufWrData), .bufWrValid(bufWrValid),
    .bufWrReady(bufWrReady), .txBufferEmptyFlag(flag), .txIrqReq(irq),
    .shifterEmptyStatus(status), .txPinOut(txPinOut), .txPinOe(txPinOe));
  uatx_rx_model uatx_rx_model_i (.clk(clk), .serLine(serLine), .nine(nine),
    .reload(reload), .rxWord(rxWord), .rxFrameOk(rxOk), .rxCount(rxCount));

  // ==========================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // holds the strobe until an edge with ready high
  task automatic wr(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    bufWrData <= d;
    bufWrValid <= 1'b1;
    @(negedge clk);
    while (bufWrReady !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    bufWrValid <= 1'b0;
  endtask

  task automatic frame(input int k, input logic [8:0] exp);
    int n;
    n = 0;
    while (rxCount < k && n < 12000) begin
      @(negedge clk);
      n++;
    end
    check(16'(rxWord), 16'(exp));
    check(16'(rxOk), 16'h0001);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_frame8();
    check(16'(txPinOut), 16'h0001);
    check(16'(txPinOe), 16'h0001);
    wr(8'hA5);
    cyc(10);
    check(16'(status), 16'h0000);
    frame(1, 9'h0A5);
    // the model reports mid stop bit; let the stop bit run out
    cyc(40);
    check(16'(status), 16'h0001);
    check(16'(flag), 16'h0001);
    $display("test frame8 done");
  endtask

  task automatic t_irq_nine();
    check(16'(irq), 16'h0000);
    tx_interrupt_enable <= 1'b1;
    cyc(3);
    check(16'(irq), 16'h0001);
    nine <= 1'b1;
    ninth <= 1'b1;
    wr(8'h3C);
    ninth <= 1'b0;
    wr(8'hC3);
    wr(8'h81);
    cyc(3);
    check(16'(bufWrReady), 16'h0000);
    check(16'(flag), 16'h0000);
    check(16'(irq), 16'h0000);
    frame(2, 9'h13C);
    frame(3, 9'h0C3);
    frame(4, 9'h081);
    nine <= 1'b0;
    cyc(40);
    check(16'(status), 16'h0001);
    check(16'(irq), 16'h0001);
    $display("test irq_nine done");
  endtask

  task automatic t_baud_sleep();
    int n;
    n = 0;
    reload <= 8'h03;
    sleepMode <= 1'b1;
    wr(8'h5A);
    cyc(300);
    check(16'(status), 16'h0001);
    sleepMode <= 1'b0;
    while (status !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (status === 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= 2558 && n <= 2562), 16'h0001);
    frame(5, 9'h05A);
    $display("test baud_sleep done");
  endtask

  task automatic t_abort();
    wr(8'hFF);
    cyc(200);
    txe <= 1'b0;
    cyc(2);
    check(16'(txPinOe), 16'h0000);
    check(16'(status), 16'h0001);
    cyc(3000);
    cms <= 1'b1;
    txe <= 1'b1;
    cyc(2);
    check(16'(txPinOe), 16'h0000);
    cms <= 1'b0;
    spe <= 1'b0;
    txe <= 1'b0;
    cyc(2);
    check(16'(txPinOe), 16'h0000);
    spe <= 1'b1;
    wr(8'h55);
    cyc(2);
    txe <= 1'b1;
    frame(7, 9'h055);
    $display("test abort done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    check(16'({flag, status, txPinOe, irq}), 16'h000C);
    @(posedge clk);
    spe <= 1'b1;
    txe <= 1'b1;
    cyc(3);
    t_frame8();
    t_irq_nine();
    t_baud_sleep();
    t_abort();
    conclude();
  end

  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule // tb_uatx_transmitter

`default_nettype wire
